// ---- rtl/chgopt_defines.svh ----
`ifndef CHGOPT_DEFINES_SVH
`define CHGOPT_DEFINES_SVH

// Serial bus identity of this charger and the command code of the option word.
`define CHGOPT_SMB_ADDR     7'h09
`define CHGOPT_CMD_OPTIONS  8'h12

// Power-on value of the option word and the bits the host may write.
`define CHGOPT_POR          16'hf902
`define CHGOPT_WR_MASK      16'hffeb

// Field positions inside the option word.
`define CHGOPT_BIT_DEPL_HI  12
`define CHGOPT_BIT_DEPL_LO  11
`define CHGOPT_BIT_FREQ_UP  10
`define CHGOPT_BIT_FREQ_EN  9
`define CHGOPT_BIT_HS_SHORT 8
`define CHGOPT_BIT_LS_SHORT 7
`define CHGOPT_BIT_LEARN    6
`define CHGOPT_BIT_MON_SEL  5
`define CHGOPT_BIT_ADAPTER  4
`define CHGOPT_BIT_BOOST_EN 3
`define CHGOPT_BIT_BOOST_IN 2
`define CHGOPT_BIT_OCP_EN   1

// Depletion fractions of the regulation limit in 1/65536 units.
`define CHGOPT_DEPL_F00     17'd38791
`define CHGOPT_DEPL_F01     17'd41058
`define CHGOPT_DEPL_F11     17'd46511

// Rising hysteresis of the depletion comparator, in mV and in voltage codes.
`define CHGOPT_HYST_MV      340
`define CHGOPT_VLSB_MV      16
`define CHGOPT_HYST_CODE    12'((`CHGOPT_HYST_MV) / (`CHGOPT_VLSB_MV))

`endif

// ---- rtl/chgopt_pkg.sv ----
`default_nettype none

package chgopt_pkg;

    // Learn cycle controller states.
    typedef enum logic [1:0] {
        LRN_IDLE = 2'b01,
        LRN_RUN  = 2'b10
    } chgopt_learn_e;

    // Settings handed to the analog power stage.
    typedef struct packed {
        logic [1:0] depl_sel;
        logic       freq_up;
        logic       freq_en;
        logic       hs_short_en;
        logic       ls_short_high;
        logic       mon_charge;
        logic       ocp_en;
    } chgopt_ctrl_s;

endpackage : chgopt_pkg

`default_nettype wire

// ---- rtl/chgopt_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

module chgopt_sync2 (
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);

    logic [3:0] meta_q;

    // Two stages; only the second stage is seen by other logic.
    // Bus lines reset to their idle high level, status levels to low.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            meta_q   <= 4'h3;
            sync_out <= 4'h3;
        end else if (ce_in) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : chgopt_sync2

`default_nettype wire

// ---- rtl/chgopt_depletion.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgopt_defines.svh"

module chgopt_depletion (
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic [10:0] vreg_code_in,
    input  wire logic [10:0] vbat_code_in,
    input  wire logic [1:0]  sel_in,
    output logic             depleted_out
);

    logic [11:0] thr;

    // Falling threshold as a fraction of the regulation code, rounded up so that
    // every battery code below the exact fraction counts as depleted.
    function automatic logic [11:0] depl_thr(input logic [10:0] v, input logic [1:0] s);
        logic [16:0] f;
        logic [27:0] p;
        f = `CHGOPT_DEPL_F11;
        if (s == 2'b00) begin
            f = `CHGOPT_DEPL_F00;
        end else if (s == 2'b01) begin
            f = `CHGOPT_DEPL_F01;
        end
        p = 28'(v) * 28'(f) + 28'h000ffff;
        return p[27:16];
    endfunction : depl_thr

    assign thr = depl_thr(vreg_code_in, sel_in); // [R01]

    // Falls below the threshold, rises again only past the hysteresis.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            depleted_out <= 1'b0;
        end else if (ce_in) begin
            if (vreg_code_in == 11'h000) begin
                depleted_out <= 1'b0; // [R04]
            end else if (12'(vbat_code_in) < thr) begin
                depleted_out <= 1'b1;
            end else if (12'(vbat_code_in) >= thr + `CHGOPT_HYST_CODE) begin
                depleted_out <= 1'b0;
            end
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    a_depl_zero_vreg: assert property (ce_in && vreg_code_in == 11'h000 |=> !depleted_out) // [R04]
        else $error("Depletion flagged with zero regulation setting.");
    a_depl_code_00: assert property (ce_in && sel_in == 2'b00 && vreg_code_in == 11'd1000
        && vbat_code_in == 11'd591 |=> depleted_out) // [R01]
        else $error("Depletion threshold for code 00 is wrong.");

endmodule : chgopt_depletion

`default_nettype wire

// ---- rtl/chgopt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgopt_defines.svh"

// Operation
// [R01] Two-bit field picks depletion threshold: 59.19, 62.65 or 70.97 percent.
// [R02] Learn cycle below threshold: battery switch off, adapter switch on.
// [R03] Boost active and battery below threshold: boost stops.
// [R04] Zero charge voltage setting disables the depletion comparison entirely.
// [R05] Frequency adjust bit: 0 lowers switching frequency 18 percent, 1 raises.
// [R06] Frequency adjust enable gates the shift; resets to zero, no shift.
// [R07] High-side short comparator: 0 disabled, 1 gives 750mV threshold, default.
// [R08] Low-side short comparator: 0 gives 135mV, 1 gives 230mV, boost limit too.
// [R09] Host writes learn bit one: adapter switch off, battery switch on.
// [R10] Learn ending at depletion clears the learn bit by itself.
// [R11] Host writes learn bit zero: learn stops, adapter path restored; resets zero.
// [R12] Monitor select: 0 routes adapter current amplifier, 1 charge current.
// [R13] Adapter presence bit reads detect input level; zero after power-on.
// [R14] Boost enable bit permits boost; resets to zero.
// [R15] Boost indication bit reads one while boosting; zero after power-on.
// [R16] Input over-current bit: 0 disabled, 1 trips at 3.33x limit.
// [R17] Host reaches the option word by word writes and reads, command 0x12.
// [R18] Host writes to the two status bit positions are ignored.
module chgopt_top
    import chgopt_pkg::*;
(
    input  wire logic         ref_clk_in,
    input  wire logic         resetn_in,
    input  wire logic         ce_in,
    input  wire logic         smb_scl_in,
    input  wire logic         smb_sda_in,
    output logic              smb_sda_out,
    output logic              smb_sda_oe_out,
    input  wire logic         adapter_detect_in,
    input  wire logic         boost_demand_in,
    input  wire logic [15:0]  charge_voltage_setting_in,
    input  wire logic [10:0]  battery_voltage_in,
    output chgopt_ctrl_s      analog_ctrl_out,
    output logic              battery_path_switch_out,
    output logic              adapter_path_switch_out,
    output logic              boost_active_out
);

    logic [3:0]    pins_s;
    logic          scl_s;
    logic          sda_s;
    logic          adapter_s;
    logic          demand_s;
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    logic          bus_active_q;
    logic          tx_q;
    logic          mack_q;
    logic [3:0]    bit_cnt_q;
    logic [2:0]    byte_idx_q;
    logic [7:0]    rx_shift_q;
    logic [7:0]    tx_shift_q;
    logic [7:0]    rd_high_q;
    logic [7:0]    low_q;
    logic          wr_pulse_q;
    logic [15:0]   wr_data_q;
    logic [15:0]   reg_q;
    logic [15:0]   reg_d;
    chgopt_learn_e learn_q;
    logic          learn_done;
    logic          depleted;
    logic          boost_q;

    // Pins from the other party are brought onto the clock first.
    chgopt_sync2 u_sync (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .async_in   ({boost_demand_in, adapter_detect_in, smb_sda_in, smb_scl_in}),
        .sync_out   (pins_s)
    );

    assign scl_s     = pins_s[0];
    assign sda_s     = pins_s[1];
    assign adapter_s = pins_s[2];
    assign demand_s  = pins_s[3];

    // Delayed copies of the synchronised bus lines for edge detection.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_in) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Bus events: clock edges, start and stop while the clock is high.
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // The data line is only ever pulled low, so its driven level stays zero.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            smb_sda_out <= 1'b0;
        end else if (ce_in) begin
            smb_sda_out <= 1'b0;
        end
    end

    // Serial slave engine: address, command, two data bytes, or a read of two bytes.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            bus_active_q   <= 1'b0;
            tx_q           <= 1'b0;
            mack_q         <= 1'b0;
            bit_cnt_q      <= 4'h0;
            byte_idx_q     <= 3'h0;
            rx_shift_q     <= 8'h00;
            tx_shift_q     <= 8'h00;
            rd_high_q      <= 8'h00;
            low_q          <= 8'h00;
            wr_pulse_q     <= 1'b0;
            wr_data_q      <= 16'h0000;
            smb_sda_oe_out <= 1'b0;
        end else if (ce_in) begin
            wr_pulse_q <= 1'b0;
            if (start_det) begin
                bus_active_q   <= 1'b1;
                tx_q           <= 1'b0;
                mack_q         <= 1'b0;
                bit_cnt_q      <= 4'h0;
                byte_idx_q     <= 3'h0;
                smb_sda_oe_out <= 1'b0;
            end else if (stop_det) begin
                bus_active_q   <= 1'b0;
                tx_q           <= 1'b0;
                mack_q         <= 1'b0;
                smb_sda_oe_out <= 1'b0;
            end else if (bus_active_q && scl_rise) begin
                if (bit_cnt_q != 4'h8) begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (tx_q) begin
                        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                    end else begin
                        rx_shift_q <= {rx_shift_q[6:0], sda_s};
                    end
                end else if (mack_q) begin
                    // Master acknowledge: low asks for the high byte, high ends it.
                    mack_q <= 1'b0;
                    if (sda_s) begin
                        bus_active_q <= 1'b0;
                        tx_q         <= 1'b0;
                    end else begin
                        bit_cnt_q  <= 4'h0;
                        tx_shift_q <= rd_high_q;
                    end
                end else begin
                    bit_cnt_q <= 4'h0;
                end
            end else if (bus_active_q && scl_fall) begin
                if (bit_cnt_q == 4'h8 && tx_q) begin
                    smb_sda_oe_out <= 1'b0;
                    mack_q         <= 1'b1;
                end else if (bit_cnt_q == 4'h8) begin
                    smb_sda_oe_out <= 1'b1;
                    byte_idx_q     <= byte_idx_q + 3'h1;
                    if (byte_idx_q == 3'h0) begin
                        if (rx_shift_q[7:1] != `CHGOPT_SMB_ADDR) begin
                            smb_sda_oe_out <= 1'b0;
                            bus_active_q   <= 1'b0;
                        end else if (rx_shift_q[0]) begin
                            // Both bytes are captured together so the word is coherent.
                            tx_q       <= 1'b1;
                            tx_shift_q <= reg_q[7:0];
                            rd_high_q  <= reg_q[15:8];
                        end
                    end else if (byte_idx_q == 3'h1) begin
                        if (rx_shift_q != `CHGOPT_CMD_OPTIONS) begin // [R17]
                            smb_sda_oe_out <= 1'b0;
                            bus_active_q   <= 1'b0;
                        end
                    end else if (byte_idx_q == 3'h2) begin
                        low_q <= rx_shift_q;
                    end else if (byte_idx_q == 3'h3) begin
                        wr_data_q  <= {rx_shift_q, low_q};
                        wr_pulse_q <= 1'b1;
                    end else begin
                        smb_sda_oe_out <= 1'b0;
                        bus_active_q   <= 1'b0;
                    end
                end else if (tx_q) begin
                    smb_sda_oe_out <= ~tx_shift_q[7];
                end else begin
                    smb_sda_oe_out <= 1'b0;
                end
            end
        end
    end

    // Learn ends by itself once the battery is depleted.
    assign learn_done = (learn_q == LRN_RUN) && reg_q[`CHGOPT_BIT_LEARN] && depleted; // [R10]

    // Option word: host write under mask, self-clearing learn, live status bits.
    always_comb begin
        reg_d = reg_q;
        if (wr_pulse_q) begin
            reg_d = (wr_data_q & `CHGOPT_WR_MASK) | (reg_q & ~`CHGOPT_WR_MASK); // [R18]
        end else if (learn_done) begin
            reg_d[`CHGOPT_BIT_LEARN] = 1'b0; // [R10]
        end
        reg_d[`CHGOPT_BIT_ADAPTER]  = adapter_s; // [R13]
        reg_d[`CHGOPT_BIT_BOOST_IN] = boost_q;   // [R15]
    end

    // A host write in the same cycle as the self-clear wins.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            reg_q <= `CHGOPT_POR;
        end else if (ce_in) begin
            reg_q <= reg_d;
        end
    end

    // Depletion comparator fed by the regulation code and the battery reading.
    chgopt_depletion u_depl (
        .ref_clk_in   (ref_clk_in),
        .resetn_in    (resetn_in),
        .ce_in        (ce_in),
        .vreg_code_in (charge_voltage_setting_in[14:4]),             // [R04]
        .vbat_code_in (battery_voltage_in),
        .sel_in       (reg_q[`CHGOPT_BIT_DEPL_HI:`CHGOPT_BIT_DEPL_LO]), // [R01]
        .depleted_out (depleted)
    );

    // Learn cycle controller.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            learn_q <= LRN_IDLE;
        end else if (ce_in) begin
            case (learn_q)
                LRN_IDLE: begin
                    if (reg_q[`CHGOPT_BIT_LEARN]) begin
                        learn_q <= LRN_RUN; // [R09]
                    end
                end
                LRN_RUN: begin
                    if (!reg_q[`CHGOPT_BIT_LEARN]) begin
                        learn_q <= LRN_IDLE; // [R11]
                    end else if (depleted) begin
                        learn_q <= LRN_IDLE; // [R02]
                    end
                end
                default: begin
                    learn_q <= LRN_IDLE;
                end
            endcase
        end
    end

    // Boost runs only when permitted, asked for, on adapter and not depleted.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            boost_q <= 1'b0;
        end else if (ce_in) begin
            boost_q <= reg_q[`CHGOPT_BIT_BOOST_EN] & demand_s & adapter_s // [R14]
                       & ~depleted & (learn_q == LRN_IDLE);               // [R03]
        end
    end

    assign boost_active_out = boost_q;

    // Path switches: battery feeds the system while learning or boosting.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            battery_path_switch_out <= 1'b0;
            adapter_path_switch_out <= 1'b1;
        end else if (ce_in) begin
            battery_path_switch_out <= (learn_q == LRN_RUN) | boost_q; // [R09] [R02]
            adapter_path_switch_out <= (learn_q != LRN_RUN);           // [R11]
        end
    end

    // Settings for the power stage, registered from the option word.
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            analog_ctrl_out <= '0;
        end else if (ce_in) begin
            analog_ctrl_out.depl_sel      <= reg_q[`CHGOPT_BIT_DEPL_HI:`CHGOPT_BIT_DEPL_LO];
            analog_ctrl_out.freq_up       <= reg_q[`CHGOPT_BIT_FREQ_UP];  // [R05]
            analog_ctrl_out.freq_en       <= reg_q[`CHGOPT_BIT_FREQ_EN];  // [R06]
            analog_ctrl_out.hs_short_en   <= reg_q[`CHGOPT_BIT_HS_SHORT]; // [R07]
            analog_ctrl_out.ls_short_high <= reg_q[`CHGOPT_BIT_LS_SHORT]; // [R08]
            analog_ctrl_out.mon_charge    <= reg_q[`CHGOPT_BIT_MON_SEL];  // [R12]
            analog_ctrl_out.ocp_en        <= reg_q[`CHGOPT_BIT_OCP_EN];   // [R16]
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    a_learn_self_clear: assert property (ce_in && learn_done && !wr_pulse_q // [R10]
        |=> !reg_q[`CHGOPT_BIT_LEARN])
        else $error("Learn bit not cleared at depletion.");
    a_learn_paths: assert property (ce_in && learn_q == LRN_RUN // [R09]
        |=> battery_path_switch_out && !adapter_path_switch_out)
        else $error("Learn cycle did not move the path switches.");
    a_idle_paths: assert property (ce_in && learn_q == LRN_IDLE && !boost_q // [R11]
        |=> !battery_path_switch_out && adapter_path_switch_out)
        else $error("Adapter path not restored outside learn.");
    a_boost_depl_stop: assert property (ce_in && depleted |=> !boost_active_out) // [R03]
        else $error("Boost continued below depletion threshold.");
    a_boost_gate_off: assert property (ce_in && !reg_q[`CHGOPT_BIT_BOOST_EN] // [R14]
        |=> !boost_active_out)
        else $error("Boost ran while not enabled.");
    a_status_ro_bits: assert property (ce_in && wr_pulse_q // [R18]
        |=> reg_q[`CHGOPT_BIT_ADAPTER] == $past(adapter_s)
            && reg_q[`CHGOPT_BIT_BOOST_IN] == $past(boost_q))
        else $error("Host write reached a status bit.");
    a_adapter_ind: assert property (ce_in ##1 ce_in // [R13]
        |-> reg_q[`CHGOPT_BIT_ADAPTER] == $past(adapter_s))
        else $error("Adapter presence bit does not follow detect.");
    a_ctrl_follow: assert property (ce_in // [R05]
        |=> analog_ctrl_out.freq_up == $past(reg_q[`CHGOPT_BIT_FREQ_UP])
            && analog_ctrl_out.mon_charge == $past(reg_q[`CHGOPT_BIT_MON_SEL]))
        else $error("Power stage settings do not follow the option word.");
    a_cmd_reject: assert property (ce_in && bus_active_q && scl_fall && bit_cnt_q == 4'h8
        && !tx_q && byte_idx_q == 3'h1 && rx_shift_q != `CHGOPT_CMD_OPTIONS // [R17]
        |=> !smb_sda_oe_out && !bus_active_q)
        else $error("Foreign command code was acknowledged.");

endmodule : chgopt_top

`default_nettype wire

// ---- testbench/chgopt_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgopt_defines.svh"

// Bit-level serial bus master; the data line is open drain with a pull-up.
module chgopt_host_model (
    input  wire logic ref_clk_in,
    input  wire logic sda_oe_in,
    output logic      scl_out,
    output logic      sda_out
);
    logic pull_low_q;

    // Wired-AND of both drivers; a released line floats up to one.
    assign sda_out = ~(pull_low_q | sda_oe_in);

    // The bus idles with both lines high.
    initial begin
        scl_out    = 1'b1;
        pull_low_q = 1'b0;
    end

    // One half-period of the bus clock, well above the four-clock minimum.
    task automatic half();
        repeat (10) @(posedge ref_clk_in);
        #1;
    endtask : half

    // Drives one bit while the clock is low, then pulses the clock.
    task automatic put_bit(input logic b);
        pull_low_q = ~b;
        half();
        scl_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask : put_bit

    // Releases the line and samples it just before the clock falls.
    task automatic get_bit(output logic b);
        pull_low_q = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        b = sda_out;
        scl_out = 1'b0;
    endtask : get_bit

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        pull_low_q = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        pull_low_q = 1'b1;
        half();
        scl_out = 1'b0;
    endtask : start

    // Stop: data rises while the clock is high.
    task automatic stop();
        pull_low_q = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        pull_low_q = 1'b0;
        half();
    endtask : stop

    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic nb;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(nb);
        ack = ~nb;
    endtask : byte_out

    // Receives a byte and answers with acknowledge, or not on the last one.
    task automatic byte_in(output logic [7:0] v, input logic last);
        for (int i = 7; i >= 0; i--) begin
            get_bit(v[i]);
        end
        put_bit(last);
    endtask : byte_in

    // Word write: address, command, low byte, then high byte.
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
        logic a0, a1, a2, a3;
        start();
        byte_out({`CHGOPT_SMB_ADDR, 1'b0}, a0);
        byte_out(cmd, a1);
        byte_out(d[7:0], a2);
        byte_out(d[15:8], a3);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask : write_word

    // Word read: command by write, repeated start, then two bytes back.
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        byte_out({`CHGOPT_SMB_ADDR, 1'b0}, a0);
        byte_out(cmd, a1);
        start();
        byte_out({`CHGOPT_SMB_ADDR, 1'b1}, a2);
        byte_in(d[7:0], 1'b0);
        byte_in(d[15:8], 1'b1);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_word
endmodule : chgopt_host_model
`default_nettype wire

// ---- testbench/tb_charger_option_fields.sv ----
`timescale 1ns/1ps
`default_nettype none

// Checks the option word and its effect on the path switches and boost.
module tb_charger_option_fields;
    import chgopt_pkg::*;
    logic         ref_clk, resetn, ce, scl, sda, sda_oe, adapter, demand, bsw, asw, boost;
    logic  [15:0] cvs, opt, d;
    logic  [10:0] vbat;
    chgopt_ctrl_s ctrl;
    logic         depl, ok, sda_lvl;
    int           failures, check_count, cycles, seed, thr, i;
    int           codes[3] = '{0, 1, 3};
    int           pct[3]   = '{5919, 6265, 7097};
    localparam int VREG    = 1000;

    chgopt_top dut (.ref_clk_in(ref_clk), .resetn_in(resetn), .ce_in(ce), .smb_scl_in(scl),
        .smb_sda_in(sda), .smb_sda_out(sda_lvl), .smb_sda_oe_out(sda_oe),
        .adapter_detect_in(adapter), .boost_demand_in(demand),
        .charge_voltage_setting_in(cvs), .battery_voltage_in(vbat),
        .analog_ctrl_out(ctrl), .battery_path_switch_out(bsw),
        .adapter_path_switch_out(asw), .boost_active_out(boost));

    chgopt_host_model host (.ref_clk_in(ref_clk), .sda_oe_in(sda_oe), .scl_out(scl),
        .sda_out(sda));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short well beyond the expected run length.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk_word

    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %b seen %b", n, e, g);
            failures++;
        end
    endtask : chk_bit

    // Lets synchronisers, comparator and switch registers catch up.
    task automatic settle();
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : settle

    // Compares every output and the read-back word with the bench model.
    task automatic check_all();
        logic [15:0] rd;
        logic        rok, eb;
        eb = opt[3] & demand & adapter & ~depl & ~opt[6];
        chk_bit("battery switch", opt[6] | eb, bsw);
        chk_bit("adapter switch", ~opt[6], asw);
        chk_bit("boost active", eb, boost);
        chk_word("analog ctrl", {8'h00, opt[12:7], opt[5], opt[1]}, {8'h00, ctrl});
        host.read_word(8'h12, rd, rok);
        chk_bit("read ack", 1'b1, rok);
        chk_bit("sda drive level", 1'b0, sda_lvl);
        chk_word("option word", (opt & 16'hffeb) | {11'h000, adapter, 1'b0, eb, 2'b00}, rd);
    endtask : check_all

    // Writes the option word and updates the model; status bits stay read-only.
    task automatic wr(input logic [15:0] v);
        logic wok;
        host.write_word(8'h12, v, wok);
        chk_bit("write ack", 1'b1, wok);
        opt = v & 16'hffeb;
        settle();
    endtask : wr

    // Main sequence: reset, register traffic, learn cycles, boost.
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        adapter = 1'b0;
        demand = 1'b0;
        cvs = 16'(VREG << 4);
        vbat = 11'd900;
        opt = 16'hf902;
        depl = 1'b0;
        seed = 52;
        repeat (12) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        settle();
        check_all();
        for (i = 0; i < 6; i++) begin
            d = 16'($random(seed));
            d[6] = 1'b0;
            adapter = 1'($random(seed));
            wr(d);
            check_all();
        end
        host.write_word(8'h14, 16'h1234, ok);
        chk_bit("foreign command ack", 1'b0, ok);
        check_all();
        for (i = 0; i < 3; i++) begin
            vbat = 11'd900;
            depl = 1'b0;
            settle();
            wr(16'h0142 | 16'(codes[i] << 11));
            check_all();
            thr = (VREG * pct[i] + 9999) / 10000;
            vbat = 11'(thr);
            settle();
            check_all();
            vbat = 11'(thr - 1);
            settle();
            opt[6] = 1'b0;
            depl = 1'b1;
            check_all();
        end
        vbat = 11'd900;
        depl = 1'b0;
        settle();
        wr(16'hf942);
        wr(16'hf902);
        check_all();
        cvs = 16'h0000;
        vbat = 11'd0;
        wr(16'hf942);
        check_all();
        wr(16'hf902);
        cvs = 16'(VREG << 4);
        vbat = 11'd900;
        adapter = 1'b1;
        demand = 1'b1;
        wr(16'hf90a);
        check_all();
        vbat = 11'd708;
        depl = 1'b1;
        settle();
        check_all();
        vbat = 11'd900;
        depl = 1'b0;
        settle();
        check_all();
        ce = 1'b0;
        demand = 1'b0;
        settle();
        chk_bit("frozen boost", 1'b1, boost);
        ce = 1'b1;
        demand = 1'b1;
        settle();
        wr(16'hf902);
        check_all();
        tally_and_finish();
    end
endmodule : tb_charger_option_fields
`default_nettype wire
